// ==== design/wdt_top.sv ====
// Purpose : Watchdog / interval timer with peripheral bus register slave
// Assumes : One 200 MHz clock; i_rst_n is the external chip reset
// Notes   : i_internal_reset_n clears only the reset status register

`timescale 1ns/1ps

module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned PRE_W = MAX_DIV_LOG2
) (
  input  wire logic              i_core_clk,          // Core clock, 200 MHz
  input  wire logic              i_rst_n,             // External chip reset, sync, low
  input  wire logic              i_internal_reset_n,  // Internal reset, clears status
  input  wire logic              i_psel,              // APB select
  input  wire logic              i_penable,           // APB enable
  input  wire logic              i_pwrite,            // APB write
  input  wire logic [ADDR_W-1:0] i_paddr,             // APB byte address
  input  wire logic [DATA_W-1:0] i_pwdata,            // APB write data
  output logic      [DATA_W-1:0] o_prdata,            // APB read data
  output logic                   o_pready,            // APB ready
  output logic                   o_pslverr,           // APB error, unmapped address
  output logic                   o_wd_interrupt_out,  // Interrupt request, level
  output logic                   o_wd_overflow_out,   // Watchdog overflow pulse
  output logic                   o_poweron_reset_req, // Power-on reset request
  output logic                   o_manual_reset_req   // Manual reset request
);

  if (CNT_W != 8 || PRE_W < MAX_DIV_LOG2) begin : g_chk
    $error("wdt_top: unsupported CNT_W or PRE_W");
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire setup_ph  = i_psel & ~i_penable;
  wire access_ph = i_psel & i_penable;
  wire hit_ctrl  = (i_paddr == OFF_CONTROL);
  wire hit_stat  = (i_paddr == OFF_STATUS);
  wire hit_cnt   = (i_paddr == OFF_COUNTER);
  wire hit_any   = hit_ctrl | hit_stat | hit_cnt;
  wire wr_ctrl   = access_ph & i_pwrite & hit_ctrl;
  wire wr_cnt    = access_ph & i_pwrite & hit_cnt;
  wire rd_stat   = access_ph & ~i_pwrite & hit_stat;
  wire cap_stat  = setup_ph & ~i_pwrite & hit_stat;

  assign o_pready  = 1'b1;
  assign o_pslverr = access_ph & ~hit_any;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [STAT_W-1:0] flags_q, flags_d;
  logic [STAT_W-1:0] cap_q, cap_d;
  logic [DATA_W-1:0] rdata_d;
  logic              ovf_out_q;
  logic              kind_q, kind_d;
  wdt_rq_state_t     rq_q, rq_d;

  wdt_tick_if tick_bus ();

  wdt_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .tick_if    (tick_bus)
  );

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  wire       irq_en    = ctrl_q[CTRL_IEN_BIT];
  wire       wd_mode   = ctrl_q[CTRL_MODE_BIT];
  wire       timer_en  = ctrl_q[CTRL_TEN_BIT];
  wire       rst_en    = ctrl_q[CTRL_REN_BIT];
  wire       rst_kind  = ctrl_q[CTRL_KIND_BIT];
  wire [2:0] cks_field = ctrl_q[CTRL_CKS_LSB +: CKS_W];

  assign tick_bus.count_clock_select = cks_field;

  assign ctrl_d = wr_ctrl ? i_pwdata[CTRL_W-1:0] : ctrl_q;

  // ---------------------------------------------------------------
  // Counter and overflow
  // ---------------------------------------------------------------
  wire inc     = timer_en & tick_bus.tick;
  wire ovf     = inc & ~wr_cnt & (cnt_q == {CNT_W{1'b1}});
  wire ovf_wd  = ovf & wd_mode;
  wire ovf_it  = ovf & ~wd_mode;
  wire req_rst = ovf_wd & rst_en;

  // Software write beats a count in the same cycle
  assign cnt_d = wr_cnt ? i_pwdata[CNT_W-1:0]
               : inc    ? cnt_q + 1'b1
               :          cnt_q;

  // ---------------------------------------------------------------
  // Status flags, read-to-clear
  // ---------------------------------------------------------------
  // Only bits returned to software are cleared; a later set survives
  wire [STAT_W-1:0] clr_mask = rd_stat ? cap_q : '0;
  wire [STAT_W-1:0] set_mask = {ovf_it, ovf_wd};

  assign flags_d = (flags_q & ~clr_mask) | set_mask;
  assign cap_d   = cap_stat ? flags_q : cap_q;

  // ---------------------------------------------------------------
  // Read data, captured in setup phase
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (hit_ctrl) rdata_d[CTRL_W-1:0] = ctrl_q;
    if (hit_stat) rdata_d[STAT_W-1:0] = flags_q;
    if (hit_cnt)  rdata_d[CNT_W-1:0]  = cnt_q;
  end

  // ---------------------------------------------------------------
  // Reset request sequencer
  // ---------------------------------------------------------------
  always_comb begin
    rq_d   = rq_q;
    kind_d = kind_q;
    case (rq_q)
      RQ_IDLE: begin
        if (req_rst) begin
          rq_d   = RQ_HOLD;
          kind_d = rst_kind;
        end
      end
      RQ_HOLD: begin
        // Held until the next divided pulse: one full period
        if (tick_bus.tick && !req_rst) rq_d = RQ_IDLE;
      end
      default: begin
        rq_d = RQ_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_q    <= CTRL_RST;
      cnt_q     <= CNT_RST;
      cap_q     <= STAT_RST;
      o_prdata  <= '0;
      ovf_out_q <= 1'b0;
      rq_q      <= RQ_IDLE;
      kind_q    <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      cnt_q     <= cnt_d;
      cap_q     <= cap_d;
      ovf_out_q <= ovf_wd;
      rq_q      <= rq_d;
      kind_q    <= kind_d;
      if (setup_ph) o_prdata <= rdata_d;
    end
  end

  // Status has its own reset so i_internal_reset_n clears it while control and counter keep their values
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_internal_reset_n) flags_q <= STAT_RST;
    else                                  flags_q <= flags_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_wd_interrupt_out  = irq_en & (|flags_q);
  assign o_wd_overflow_out   = ovf_out_q;
  assign o_poweron_reset_req = (rq_q == RQ_HOLD) & ~kind_q;
  assign o_manual_reset_req  = (rq_q == RQ_HOLD) & kind_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_WD_FLAG : assert property (
    ovf && wd_mode && i_internal_reset_n |=> flags_q[STAT_WD_BIT] && o_wd_overflow_out)
    else $error("watchdog overflow did not set flag or pulse output");

  AST_IT_FLAG : assert property (
    ovf && !wd_mode && i_internal_reset_n |=> flags_q[STAT_IT_BIT] && !o_wd_overflow_out)
    else $error("interval overflow did not set its flag");

  AST_IRQ_GATE : assert property (
    !irq_en |-> !o_wd_interrupt_out)
    else $error("interrupt raised while disabled");

  AST_IRQ_RAISE : assert property (
    ovf && irq_en && !wr_ctrl && i_internal_reset_n |=> o_wd_interrupt_out)
    else $error("overflow did not raise enabled interrupt");

  AST_RST_KIND : assert property (
    rq_q == RQ_IDLE && req_rst |=> (o_manual_reset_req == $past(rst_kind))
                                   && (o_poweron_reset_req != $past(rst_kind)))
    else $error("wrong reset kind requested");

  AST_NO_RST : assert property (
    rq_q == RQ_IDLE && !req_rst |=> !o_poweron_reset_req && !o_manual_reset_req)
    else $error("reset requested without enabled watchdog overflow");

  AST_RQ_END : assert property (
    rq_q == RQ_HOLD && tick_bus.tick && !req_rst |=> rq_q == RQ_IDLE ##1 rq_q == RQ_IDLE)
    else $error("reset request outlived one divided period");

  AST_CNT_HOLD : assert property (
    !timer_en && !wr_cnt |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  AST_CNT_WRITE : assert property (
    wr_cnt |=> cnt_q == $past(i_pwdata[CNT_W-1:0]))
    else $error("counter write not taken at once");

  AST_CNT_STEP : assert property (
    inc && !wr_cnt |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
    else $error("counter did not advance on divided pulse");

  AST_CTRL_WRITE : assert property (
    wr_ctrl |=> ctrl_q == $past(i_pwdata[CTRL_W-1:0]))
    else $error("control write lost");

  AST_READ_CLEAR : assert property (
    rd_stat && !ovf && !$past(ovf) |=> flags_q == '0)
    else $error("status read did not clear flags");

  AST_INT_RESET : assert property (
    !i_internal_reset_n |=> flags_q == STAT_RST)
    else $error("internal reset left status flags set");

  AST_EXT_RESET : assert property (@(posedge i_core_clk) disable iff (1'b0)
    !i_rst_n |=> cnt_q == CNT_RST && ctrl_q == CTRL_RST)
    else $error("external reset did not clear counter");

  COV_WD_RESET   : cover property (req_rst ##1 o_poweron_reset_req);
  COV_WD_MANUAL  : cover property (req_rst ##1 o_manual_reset_req);
  COV_INTERVAL   : cover property (ovf_it && irq_en ##1 o_wd_interrupt_out);
  COV_READ_CLEAR : cover property (rd_stat && |flags_q);

endmodule : wdt_top

// ==== design/wdt_pkg.sv ====
// Purpose : Shared constants for the watchdog / interval timer
// Assumes : Register offsets are byte addresses on the peripheral bus
// Notes   : Divider table is log2 of each counter clock divider

package wdt_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DATA_W       = 32;
  localparam logic [15:0] OFF_CONTROL  = 16'h1100;
  localparam logic [15:0] OFF_STATUS   = 16'h1104;
  localparam logic [15:0] OFF_COUNTER  = 16'h1108;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned CTRL_IEN_BIT  = 7;
  localparam int unsigned CTRL_MODE_BIT = 6;
  localparam int unsigned CTRL_TEN_BIT  = 5;
  localparam int unsigned CTRL_REN_BIT  = 4;
  localparam int unsigned CTRL_KIND_BIT = 3;
  localparam int unsigned CTRL_CKS_LSB  = 0;
  localparam int unsigned CKS_W         = 3;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_W      = 2;
  localparam int unsigned STAT_WD_BIT = 0;
  localparam int unsigned STAT_IT_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [7:0] CNT_RST  = 8'h00;

  // ---------------------------------------------------------------
  // Counter clock dividers /2 /8 /32 /64 /256 /512 /2048 /8192
  // ---------------------------------------------------------------
  localparam int unsigned MAX_DIV_LOG2 = 13;
  localparam logic [7:0][3:0] DIV_LOG2 = {4'hd, 4'hb, 4'h9, 4'h8, 4'h6, 4'h5, 4'h3, 4'h1};

  // Reset request sequencer, one-hot
  typedef enum logic [1:0] {
    RQ_IDLE = 2'b01,
    RQ_HOLD = 2'b10
  } wdt_rq_state_t;

endpackage : wdt_pkg

// ==== design/wdt_tick_if.sv ====
// Purpose : Carries clock select and count tick between prescaler and core
// Assumes : Single clock domain
// Notes   : Tick is a one-cycle enable pulse

`timescale 1ns/1ps

interface wdt_tick_if;
  logic [2:0] count_clock_select;  // Divider code
  logic       tick;                // One-cycle count enable

  modport src (input count_clock_select, output tick);
  modport dst (output count_clock_select, input tick);
endinterface : wdt_tick_if

// ==== design/wdt_prescaler.sv ====
// Purpose : Free-running divider giving the selected counter clock pulse
// Assumes : One clock, synchronous active-low reset
// Notes   : Runs free so a pending reset request always times out

`timescale 1ns/1ps

module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int unsigned PRE_W = MAX_DIV_LOG2
) (
  input  wire logic i_core_clk,  // Core clock
  input  wire logic i_rst_n,     // Sync reset, active low
  wdt_tick_if.src   tick_if      // Select in, tick out
);

  if (PRE_W < MAX_DIV_LOG2) begin : g_chk
    $error("wdt_prescaler: PRE_W too small for largest divider");
  end

  logic [PRE_W-1:0] pre_q;
  logic [7:0]       tap;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) pre_q <= '0;
    else          pre_q <= pre_q + 1'b1;
  end

  // ---------------------------------------------------------------
  // One tap per divider code
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_tap
    localparam int unsigned W = DIV_LOG2[g];
    assign tap[g] = &pre_q[W-1:0];
  end

  assign tick_if.tick = tap[tick_if.count_clock_select];

  AST_TICK_PERIOD : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    tick_if.tick && $stable(tick_if.count_clock_select) |=> !tick_if.tick)
    else $error("divided tick lasted more than one cycle");

endmodule : wdt_prescaler

// ==== dv/wdt_pm_model.sv ====
// Purpose : Power manager and interrupt controller stand-in for the watchdog
// Assumes : Requests and overflow pulse are synchronous to the core clock
// Notes   : Counts request pulses and measures the last request width

`timescale 1ns/1ps

module wdt_pm_model (
  input  wire logic i_core_clk,    // Core clock
  input  wire logic i_poweron_req, // Power-on reset request
  input  wire logic i_manual_req,  // Manual reset request
  input  wire logic i_overflow,    // Watchdog overflow pulse
  output int        o_por_n,       // Power-on requests seen
  output int        o_man_n,       // Manual requests seen
  output int        o_ovf_n,       // Overflow pulse cycles seen
  output int        o_width        // Cycles of the last request
);
  // ---------------------------------------------------------------
  // Pulse bookkeeping
  // ---------------------------------------------------------------
  logic por_q;
  logic man_q;
  int   run;

  initial begin
    o_por_n = 0;
    o_man_n = 0;
    o_ovf_n = 0;
    o_width = 0;
    run     = 0;
  end

  // A longer overflow pulse counts more than once, so widening shows up
  always @(posedge i_core_clk) begin
    if (i_poweron_req && !por_q) o_por_n++;
    if (i_manual_req && !man_q) o_man_n++;
    if (i_overflow === 1'b1) o_ovf_n++;
    if (i_poweron_req || i_manual_req) run++;
    else if (por_q || man_q) begin
      o_width = run;
      run     = 0;
    end
    por_q = i_poweron_req;
    man_q = i_manual_req;
  end
endmodule : wdt_pm_model

// ==== dv/tb_wdt_top.sv ====
// Purpose : Self-checking bench for the watchdog / interval timer
// Assumes : Zero-wait register bus, 200 MHz core clock
// Notes   : Overflows are provoked by preloading the counter near its top

`timescale 1ns/1ps

module tb_wdt_top;
  import wdt_pkg::*;
  logic              i_core_clk, i_rst_n, i_internal_reset_n, i_psel, i_penable, i_pwrite;
  logic [ADDR_W-1:0] i_paddr;
  logic [DATA_W-1:0] i_pwdata, o_prdata, rd;
  logic              o_pready, o_pslverr, o_wd_interrupt_out, o_wd_overflow_out, err;
  logic              o_poweron_reset_req, o_manual_reset_req;
  int                n_errors = 0, n_compared = 0, por_n, man_n, ovf_n, width;
  int                divs[8] = '{2, 8, 32, 64, 256, 512, 2048, 8192};

  wdt_top i_wdt_top (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_internal_reset_n(i_internal_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_wd_interrupt_out(o_wd_interrupt_out),
    .o_wd_overflow_out(o_wd_overflow_out), .o_poweron_reset_req(o_poweron_reset_req),
    .o_manual_reset_req(o_manual_reset_req));
  wdt_pm_model i_wdt_pm_model (.i_core_clk(i_core_clk), .i_poweron_req(o_poweron_reset_req),
    .i_manual_req(o_manual_reset_req), .i_overflow(o_wd_overflow_out), .o_por_n(por_n), .o_man_n(man_n),
    .o_ovf_n(ovf_n), .o_width(width));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc

  // Leading edge keeps back-to-back calls from driving twice in one step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d; i_penable <= 1'b0;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    @(posedge i_core_clk);
    rd = o_prdata; err = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask : apb

  // Wide enough for the four model counters compared as one word
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h range %h..%h", $time, g, lo, hi);
    end
  endtask : chk_rng

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk

  // Preload just below wrap, run, then stop the timer
  task automatic ovf(input logic [7:0] c, input int w);
    wr(OFF_CONTROL, {24'h0, c});
    wr(OFF_COUNTER, 32'h0000_00fe);
    cyc(w);
    wr(OFF_CONTROL, {24'h0, c & 8'hdf});
  endtask : ovf

  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Clock, reset, watchdog
  // ---------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  initial begin
    #400_000;
    n_errors++;
    end_of_test();
  end

  initial begin
    i_rst_n = 1'b0; i_internal_reset_n = 1'b1; i_psel = 1'b0; i_penable = 1'b0;
    i_pwrite = 1'b0; i_paddr = '0; i_pwdata = '0;
    cyc(6);
    i_rst_n <= 1'b1;
    rdchk(OFF_CONTROL, 32'h0000_0000);
    rdchk(OFF_STATUS, 32'h0000_0000);
    rdchk(OFF_COUNTER, 32'h0000_0000);
    wr(OFF_CONTROL, 32'hffff_ff5a);
    rdchk(OFF_CONTROL, 32'h0000_005a);
    ovf(8'ha0, 20);
    chk({31'h0, o_wd_interrupt_out}, 32'h1);
    chk({por_n, man_n, ovf_n}, 96'h0);
    // 0xFE plus 11 or 12 ticks of /2 over 23 enabled edges: wrapped once
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    chk_rng(rd, 32'd9, 32'd10);
    rdchk(OFF_STATUS, 32'h0000_0002);
    rdchk(OFF_STATUS, 32'h0000_0000);
    cyc(2);
    chk({31'h0, o_wd_interrupt_out}, 32'h0);
    ovf(8'h60, 20);
    chk({31'h0, o_wd_interrupt_out}, 32'h0);
    chk({por_n, man_n, ovf_n}, {32'd0, 32'd0, 32'd1});
    rdchk(OFF_STATUS, 32'h0000_0001);
    ovf(8'hf0, 20);
    chk({31'h0, o_wd_interrupt_out}, 32'h1);
    chk({por_n, man_n, ovf_n, width}, {32'd1, 32'd0, 32'd2, 32'd2});
    rdchk(OFF_STATUS, 32'h0000_0001);
    ovf(8'hf9, 60);
    chk({por_n, man_n, ovf_n, width}, {32'd1, 32'd1, 32'd3, 32'd8});
    rdchk(OFF_STATUS, 32'h0000_0001);
    wr(OFF_CONTROL, 32'h0000_00f0);
    repeat (20) begin
      cyc(100);
      wr(OFF_COUNTER, 32'h0000_0000);
    end
    wr(OFF_CONTROL, 32'h0000_0000);
    chk({por_n, man_n, ovf_n}, {32'd1, 32'd1, 32'd3});
    rdchk(OFF_STATUS, 32'h0000_0000);
    wr(OFF_COUNTER, 32'h0000_0037);
    cyc(50);
    rdchk(OFF_COUNTER, 32'h0000_0037);
    for (int k = 0; k < 8; k++) begin
      wr(OFF_COUNTER, 32'h0000_0000);
      wr(OFF_CONTROL, 32'h0000_0020 | k);
      cyc(4 * divs[k] - 3);
      wr(OFF_CONTROL, 32'h0000_0000);
      apb(1'b0, OFF_COUNTER, 32'h0000_0000);
      chk_rng(rd, 32'd3, 32'd5);
    end
    ovf(8'ha0, 20);
    wr(OFF_COUNTER, 32'h0000_0055);
    @(posedge i_core_clk);
    i_internal_reset_n <= 1'b0;
    @(posedge i_core_clk);
    i_internal_reset_n <= 1'b1;
    rdchk(OFF_STATUS, 32'h0000_0000);
    rdchk(OFF_COUNTER, 32'h0000_0055);
    apb(1'b0, 16'h110c, 32'h0000_0000);
    chk({rd, 31'h0, err}, {32'h0, 32'h1});
    wr(OFF_STATUS, 32'h0000_0003);
    rdchk(OFF_STATUS, 32'h0000_0000);
    wr(OFF_COUNTER, 32'h0000_0099);
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    cyc(2);
    i_rst_n <= 1'b1;
    rdchk(OFF_COUNTER, 32'h0000_0000);
    rdchk(OFF_CONTROL, 32'h0000_0000);
    end_of_test();
  end
endmodule : tb_wdt_top
